//--- iets_consts.vh
// Constants shared by the interrupt and event transfer system.
// Assumes a 16-bit register port with an 8-bit word address.
// Behaviour
// R1 - Each node's route bit sends its request to the controller or event transfer.
// R2 - An event transfer steals exactly one cycle, no vector, no program stop.
// R3 - A transfer moves a byte or word, then bumps source and/or destination.
// R4 - Each transfer decrements the channel counter unless continuous mode is set.
// R5 - A counter at zero turns the request into a standard vectored interrupt.
// R6 - Eight transfer channels, each with source, destination and counter.
// R7 - Vector follows selection after 7 clocks with jump cache, 11 without.
// R8 - 96 nodes, each with request flag, enable flag and priority field.
// R9 - Shared nodes take their source as the source select register says.
// R10 - External request unit: 4 edge channels, routing matrix, 4 gating units.
// R11 - Each edge channel detects rising, falling or both edges as programmed.
// R12 - Each gating unit passes routed events on pattern match or on miss.
// R13 - A hardware trap vectors at once and sets its own trap flag bit.
// R14 - A trap preempts anything except a trap service of higher priority.
// R15 - During a trap service standard interrupts and transfers are held off.
// R16 - Three service request pins produce two system request traps.
// R17 - A software exception carries a number that selects the vector taken.
// R18 - Software setting a request flag raises the node like hardware would.
// R19 - Highest priority requesting enabled node wins; ties go to lowest index.
`ifndef IETS_CONSTS_VH
`define IETS_CONSTS_VH
`define NODES 96
`define NODE_CW 12
`define PRIO_W 4
`define F_PRIO 0
`define F_EN 6
`define F_REQ 7
`define F_PEC 8
`define F_CH 9
`define NODE_WMASK 12'hfcf
`define SHARED_BASE 92
`define A_NODE_LAST 8'h5f
`define A_SRCSEL 8'h60
`define A_TRAP 8'h61
`define A_ESR 8'h62
`define A_STAT 8'h63
`define A_ERU_HI 6'h1a
`define A_PEC_HI 3'h4
`define LAT_JC 4'h7
`define LAT_NJC 4'hb
`define TRAP_NONE 4'h8
`define TRAP_VEC_BASE 8'hf0
`define F_CNT 0
`define F_BYTE 8
`define F_INCS 9
`define F_INCD 10
`define F_CONT 11
`define GATE_PASS 2'h1
`define GATE_MATCH 2'h2
`define GATE_MISS 2'h3
`endif

//--- iets_eru.v
// External request unit: four edge channels, routing and gating units.
// Assumes synchronous inputs and a configuration write port from the top.
`timescale 1ns/1ps
`include "iets_consts.vh"
module iets_eru (
	input wire sys_clk,
	input wire reset,
	input wire cfg_wr,
	input wire [1:0] cfg_idx,
	input wire [15:0] cfg_wdata,
	output wire [15:0] cfg_rdata,
	input wire [15:0] eru_in,
	output wire [3:0] eru_req
);
	wire [55:0] cfg_flat;
	wire [3:0] det;
	wire [3:0] lvl;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : ch
			reg [13:0] cfg;
			reg prev;
			reg out;
			wire [3:0] quad = eru_in[4*g+3:4*g];
			wire cur = quad[cfg[3:2]];
			wire routed = |(det & cfg[7:4]);
			wire match = ((lvl ^ cfg[11:8]) & cfg[7:4]) == 4'h0;
			reg pass;
			assign lvl[g] = cur;
			assign det[g] = (cfg[0] & cur & ~prev) | (cfg[1] & ~cur & prev); // [R11]
			assign cfg_flat[14*g+13:14*g] = cfg;
			assign eru_req[g] = out;
			always @* begin
				case (cfg[13:12])
				`GATE_PASS: pass = 1'b1;
				`GATE_MATCH: pass = match;
				`GATE_MISS: pass = ~match;
				default: pass = 1'b0;
				endcase
			end
			always @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					cfg <= 14'h0;
					prev <= 1'b0;
					out <= 1'b0;
				end else begin
					if (cfg_wr && cfg_idx == g)
						cfg <= cfg_wdata[13:0];
					prev <= cur;
					out <= routed & pass; // [R10] [R12]
				end
			end
		end
	endgenerate
	assign cfg_rdata = {2'h0, cfg_flat[14*cfg_idx +: 14]};
endmodule // iets_eru

//--- iets_pec.v
// Peripheral event controller: eight one-cycle transfer channels.
// Assumes the top issues go only for a channel that is not exhausted.
`timescale 1ns/1ps
`include "iets_consts.vh"
module iets_pec (
	input wire sys_clk,
	input wire reset,
	input wire cfg_wr,
	input wire [2:0] cfg_ch,
	input wire [1:0] cfg_fld,
	input wire [15:0] cfg_wdata,
	output reg [15:0] cfg_rdata,
	input wire go,
	input wire [2:0] go_ch,
	output wire [7:0] exhausted,
	output reg xfer_valid,
	output reg [15:0] xfer_src,
	output reg [15:0] xfer_dst,
	output reg xfer_byte
);
	reg [11:0] ctl [0:7];
	reg [15:0] sp [0:7];
	reg [15:0] dp [0:7];
	wire [11:0] gc = ctl[go_ch];
	wire [15:0] step = gc[`F_BYTE] ? 16'h1 : 16'h2;
	wire wr_go = cfg_wr && cfg_ch == go_ch;
	integer i;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : ex
			assign exhausted[g] = ctl[g][7:0] == 8'h0 && !ctl[g][`F_CONT];
		end
	endgenerate
	always @* begin
		case (cfg_fld)
		2'h0: cfg_rdata = {4'h0, ctl[cfg_ch]};
		2'h1: cfg_rdata = sp[cfg_ch];
		2'h2: cfg_rdata = dp[cfg_ch];
		default: cfg_rdata = 16'h0;
		endcase
	end
	// A software write to the serviced channel wins over the update.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (i = 0; i < 8; i = i + 1) begin
				ctl[i] <= 12'h0;
				sp[i] <= 16'h0;
				dp[i] <= 16'h0;
			end
			xfer_valid <= 1'b0;
			xfer_src <= 16'h0;
			xfer_dst <= 16'h0;
			xfer_byte <= 1'b0;
		end else begin
			xfer_valid <= go; // [R2]
			if (go) begin
				xfer_src <= sp[go_ch]; // [R3]
				xfer_dst <= dp[go_ch];
				xfer_byte <= gc[`F_BYTE];
				if (!wr_go) begin
					if (gc[`F_INCS])
						sp[go_ch] <= sp[go_ch] + step; // [R3]
					if (gc[`F_INCD])
						dp[go_ch] <= dp[go_ch] + step;
					if (!gc[`F_CONT])
						ctl[go_ch] <= gc - 12'h1; // [R4]
				end
			end
			if (cfg_wr) begin
				case (cfg_fld)
				2'h0: ctl[cfg_ch] <= cfg_wdata[11:0]; // [R6]
				2'h1: sp[cfg_ch] <= cfg_wdata;
				2'h2: dp[cfg_ch] <= cfg_wdata;
				default: ;
				endcase
			end
		end
	end
endmodule // iets_pec

//--- iets_top.v
// Interrupt and event transfer system top: nodes, arbitration, traps.
// Assumes synchronous inputs, pulse sources and a CPU that acknowledges
// interrupt and trap returns with one-cycle pulses.
`timescale 1ns/1ps
`include "iets_consts.vh"
module iets_top (
	input wire sys_clk,
	input wire reset,
	input wire [7:0] bus_addr,
	input wire [15:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [15:0] bus_rdata,
	input wire [95:0] src_req,
	input wire [15:0] eru_in,
	input wire [2:0] esr_pin,
	input wire [5:0] hw_trap,
	input wire trap_ret,
	input wire swi_valid,
	input wire [7:0] swi_num,
	input wire int_done,
	input wire jump_cache,
	output reg vec_valid,
	output reg [7:0] vec_num,
	output reg vec_is_trap,
	output wire xfer_valid,
	output wire [15:0] xfer_src,
	output wire [15:0] xfer_dst,
	output wire xfer_byte,
	output wire cpu_stall
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	function is_pec;
		input [7:0] a;
		is_pec = a[7:5] == `A_PEC_HI;
	endfunction

	function is_eru;
		input [7:0] a;
		is_eru = a[7:2] == `A_ERU_HI;
	endfunction

	reg state;
	reg [3:0] lat_cnt;
	reg [6:0] cur_node;
	reg int_busy;
	reg [3:0] srcsel;
	reg [7:0] trap_flags;
	reg [7:0] trap_pend;
	reg [3:0] trap_cur;
	reg [5:0] esr_cfg;
	reg [2:0] esr_prev;
	wire [3:0] eru_req;
	wire [7:0] exhausted;
	wire [15:0] eru_rdata;
	wire [15:0] pec_rdata;
	wire [95:0] node_src;
	wire [`NODES*`NODE_CW-1:0] node_flat;
	wire [95:0] req_v;
	wire [95:0] en_v;
	reg [95:0] clr_v;

	// System requests fire on a falling pin edge of any enabled pin.
	wire [2:0] esr_fall = esr_prev & ~esr_pin;
	wire sr0 = |(esr_fall & esr_cfg[2:0]); // [R16]
	wire sr1 = |(esr_fall & esr_cfg[5:3]); // [R16]
	wire [7:0] trap_ev = {hw_trap, sr1, sr0};
	wire [7:0] trap_all = trap_pend | trap_ev;
	wire trap_active = trap_cur != `TRAP_NONE;

	// Lowest trap index has the highest priority.
	reg trap_take;
	reg [3:0] trap_idx;
	integer t;
	always @* begin
		trap_take = 1'b0;
		trap_idx = `TRAP_NONE;
		for (t = 7; t >= 0; t = t - 1) begin
			if (trap_all[t] && t < trap_cur) begin // [R14]
				trap_take = 1'b1;
				trap_idx = t[3:0];
			end
		end
	end

	// Priority zero keeps a node out of arbitration.
	reg found;
	reg [6:0] best;
	reg [3:0] best_prio;
	integer n;
	always @* begin
		found = 1'b0;
		best = 7'h0;
		best_prio = 4'h0;
		for (n = 0; n < `NODES; n = n + 1) begin
			if (req_v[n] && en_v[n] &&
			    node_flat[n*`NODE_CW+`F_PRIO +: `PRIO_W] > best_prio) begin // [R19]
				found = 1'b1;
				best = n[6:0];
				best_prio = node_flat[n*`NODE_CW+`F_PRIO +: `PRIO_W];
			end
		end
	end

	wire [`NODE_CW-1:0] best_ctl = node_flat[best*`NODE_CW +: `NODE_CW];
	wire [2:0] best_ch = best_ctl[`F_CH +: 3];
	wire to_pec = best_ctl[`F_PEC] && !exhausted[best_ch]; // [R1] [R5]
	wire idle_ok = state == ST_IDLE && found && !trap_active && !trap_take;
	wire pec_go = idle_ok && to_pec; // [R15]
	wire start_int = idle_ok && !to_pec && !int_busy; // [R15]
	wire lat_end = state == ST_WAIT && lat_cnt == 4'h1;
	wire emit_int = lat_end && !trap_take && !swi_valid && req_v[cur_node];
	wire [3:0] lat_load = jump_cache ? `LAT_JC : `LAT_NJC;

	always @* begin
		clr_v = 96'h0;
		if (pec_go)
			clr_v[best] = 1'b1;
		if (emit_int)
			clr_v[cur_node] = 1'b1;
	end

	genvar g;
	generate
		for (g = 0; g < `NODES; g = g + 1) begin : node
			localparam [7:0] ADDR = g;
			reg [`NODE_CW-1:0] ctl;
			wire hit = bus_wr && bus_addr == ADDR;
			if (g >= `SHARED_BASE) begin : sh
				assign node_src[g] = srcsel[g-`SHARED_BASE] ?
					eru_req[g-`SHARED_BASE] : src_req[g]; // [R9]
			end else begin : ded
				assign node_src[g] = src_req[g];
			end
			assign node_flat[g*`NODE_CW +: `NODE_CW] = ctl;
			assign req_v[g] = ctl[`F_REQ];
			assign en_v[g] = ctl[`F_EN];
			always @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					ctl <= 12'h0;
				end else begin
					if (hit)
						ctl <= bus_wdata[11:0] & `NODE_WMASK; // [R8]
					// A hardware event wins over any clear.
					ctl[`F_REQ] <= node_src[g] |
						(hit ? bus_wdata[`F_REQ] :
						 (ctl[`F_REQ] & ~clr_v[g])); // [R18]
				end
			end
		end
	endgenerate

	iets_eru u_eru (
		.sys_clk(sys_clk),
		.reset(reset),
		.cfg_wr(bus_wr && is_eru(bus_addr)),
		.cfg_idx(bus_addr[1:0]),
		.cfg_wdata(bus_wdata),
		.cfg_rdata(eru_rdata),
		.eru_in(eru_in),
		.eru_req(eru_req)
	);

	iets_pec u_pec (
		.sys_clk(sys_clk),
		.reset(reset),
		.cfg_wr(bus_wr && is_pec(bus_addr)),
		.cfg_ch(bus_addr[4:2]),
		.cfg_fld(bus_addr[1:0]),
		.cfg_wdata(bus_wdata),
		.cfg_rdata(pec_rdata),
		.go(pec_go),
		.go_ch(best_ch),
		.exhausted(exhausted),
		.xfer_valid(xfer_valid),
		.xfer_src(xfer_src),
		.xfer_dst(xfer_dst),
		.xfer_byte(xfer_byte)
	);

	assign cpu_stall = xfer_valid; // [R2]

	// Interrupt sequencer; a trap aborts the wait and the flag stays set.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			lat_cnt <= 4'h0;
			cur_node <= 7'h0;
			int_busy <= 1'b0;
		end else begin
			if (emit_int)
				int_busy <= 1'b1;
			else if (int_done)
				int_busy <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start_int) begin
					state <= ST_WAIT;
					cur_node <= best;
					lat_cnt <= lat_load - 4'h1; // [R7]
				end
			end
			ST_WAIT: begin
				if (trap_take || !req_v[cur_node] || emit_int)
					state <= ST_IDLE; // [R15]
				else if (!lat_end)
					lat_cnt <= lat_cnt - 4'h1; // [R7]
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Vector output: trap first, then software exception, then node.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			vec_valid <= 1'b0;
			vec_num <= 8'h0;
			vec_is_trap <= 1'b0;
		end else begin
			vec_valid <= trap_take | swi_valid | emit_int;
			vec_is_trap <= trap_take;
			if (trap_take)
				vec_num <= `TRAP_VEC_BASE + {4'h0, trap_idx}; // [R13]
			else if (swi_valid)
				vec_num <= swi_num; // [R17]
			else if (emit_int)
				vec_num <= {1'b0, cur_node}; // [R5]
		end
	end

	// Nested trap returns drop straight to no trap in service.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			trap_pend <= 8'h0;
			trap_cur <= `TRAP_NONE;
			trap_flags <= 8'h0;
			esr_prev <= 3'h7;
			esr_cfg <= 6'h0;
			srcsel <= 4'h0;
		end else begin
			esr_prev <= esr_pin;
			trap_pend <= trap_all &
				~(trap_take ? (8'h1 << trap_idx) : 8'h0);
			if (trap_take)
				trap_cur <= trap_idx; // [R14]
			else if (trap_ret)
				trap_cur <= `TRAP_NONE;
			// Write one to clear; a new trap in the same cycle wins.
			trap_flags <= (trap_flags &
				~((bus_wr && bus_addr == `A_TRAP) ?
				  bus_wdata[7:0] : 8'h0)) | trap_ev; // [R13]
			if (bus_wr && bus_addr == `A_ESR)
				esr_cfg <= bus_wdata[5:0];
			if (bus_wr && bus_addr == `A_SRCSEL)
				srcsel <= bus_wdata[3:0]; // [R9]
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus_rdata <= 16'h0;
		end else if (bus_rd) begin
			if (bus_addr <= `A_NODE_LAST)
				bus_rdata <= {4'h0, node_flat[bus_addr*`NODE_CW +: `NODE_CW]};
			else if (bus_addr == `A_SRCSEL)
				bus_rdata <= {12'h0, srcsel};
			else if (bus_addr == `A_TRAP)
				bus_rdata <= {8'h0, trap_flags};
			else if (bus_addr == `A_ESR)
				bus_rdata <= {10'h0, esr_cfg};
			else if (bus_addr == `A_STAT)
				bus_rdata <= {2'h0, int_busy, state, trap_cur, 1'b0, cur_node};
			else if (is_eru(bus_addr))
				bus_rdata <= eru_rdata;
			else if (is_pec(bus_addr))
				bus_rdata <= pec_rdata;
			else
				bus_rdata <= 16'h0;
		end else begin
			bus_rdata <= 16'h0;
		end
	end
endmodule // iets_top

//--- iets_assertions.sv
// Port checker for the interrupt and event transfer system.
// Assumes it is bound to iets_top and sees only its ports.
`timescale 1ns/1ps
module iets_assertions (
	input wire sys_clk,
	input wire reset,
	input wire [7:0] bus_addr,
	input wire bus_rd,
	input wire [15:0] bus_rdata,
	input wire trap_ret,
	input wire swi_valid,
	input wire [7:0] swi_num,
	input wire vec_valid,
	input wire [7:0] vec_num,
	input wire vec_is_trap,
	input wire xfer_valid,
	input wire cpu_stall
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_trap;
		vec_valid && vec_is_trap;
	endsequence
	sequence s_no_ret;
		!trap_ret [*3];
	endsequence
	property p_stall;
		cpu_stall == xfer_valid;
	endproperty
	a_stall: assert property (p_stall)
		else $error("stall differs from transfer");
	property p_swi;
		swi_valid |=> vec_valid && (vec_is_trap || vec_num == $past(swi_num));
	endproperty
	a_swi: assert property (p_swi)
		else $error("software vector wrong");
	property p_trap_vec;
		s_trap |-> vec_num[7:3] == 5'h1e;
	endproperty
	a_trap_vec: assert property (p_trap_vec)
		else $error("trap vector out of table");
	// Software vectors stay legal inside a trap, so they are let through.
	property p_trap_hold;
		s_trap ##1 s_no_ret |->
			!xfer_valid && (!vec_valid || vec_is_trap || $past(swi_valid));
	endproperty
	a_trap_hold: assert property (p_trap_hold)
		else $error("service during trap");
	property p_rd_idle;
		!$past(bus_rd) |-> bus_rdata == 16'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");
	property p_rsv;
		$past(bus_rd) && $past(bus_addr) <= 8'h5f |->
			bus_rdata[15:12] == 4'h0 && bus_rdata[5:4] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved node bits set");
	property p_unmap;
		$past(bus_rd) && $past(bus_addr) >= 8'ha0 |-> bus_rdata == 16'h0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_reset;
		$fell(reset) |-> !vec_valid && !xfer_valid && bus_rdata == 16'h0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs busy after reset");
endmodule // iets_assertions

//--- iets_partner.sv
// Request sources and CPU core around the interrupt system.
// Assumes one-cycle vector pulses; answers them with return pulses.
`timescale 1ns/1ps
module iets_partner (
	input wire sys_clk,
	input wire reset,
	input wire vec_valid,
	input wire vec_is_trap,
	input wire slow,
	output reg [95:0] src_req,
	output reg [5:0] hw_trap,
	output reg int_done,
	output reg trap_ret
);
	reg [5:0] done_cnt;
	reg [5:0] ret_cnt;
	initial src_req = 96'h0;
	initial hw_trap = 6'h0;
	// A long trap service leaves room to see requests held off.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			done_cnt <= 6'h0;
			ret_cnt <= 6'h0;
			int_done <= 1'b0;
			trap_ret <= 1'b0;
		end else begin
			int_done <= done_cnt == 6'h1;
			trap_ret <= ret_cnt == 6'h1;
			if (vec_valid && !vec_is_trap)
				done_cnt <= slow ? 6'h14 : 6'h2;
			else if (done_cnt != 6'h0)
				done_cnt <= done_cnt - 6'h1;
			if (vec_valid && vec_is_trap)
				ret_cnt <= 6'h28;
			else if (ret_cnt != 6'h0)
				ret_cnt <= ret_cnt - 6'h1;
		end
	end
	task pulse_src(input [95:0] m);
		begin
			@(posedge sys_clk);
			src_req <= m;
			@(posedge sys_clk);
			src_req <= 96'h0;
		end
	endtask
	task pulse_trap(input [5:0] m);
		begin
			@(posedge sys_clk);
			hw_trap <= m;
			@(posedge sys_clk);
			hw_trap <= 6'h0;
		end
	endtask
endmodule // iets_partner

//--- testbench.sv
// Self-checking bench for the interrupt and event transfer system.
// Assumes iets_top, the port checker and the source and CPU model.
`timescale 1ns/1ps
`include "iets_consts.vh"
module testbench;
	reg sys_clk = 1'b0;
	reg reset = 1'b1;
	reg [7:0] bus_addr = 8'h0;
	reg [15:0] bus_wdata = 16'h0;
	reg bus_wr = 1'b0, bus_rd = 1'b0, swi_valid = 1'b0;
	reg jump_cache = 1'b1, slow = 1'b0;
	reg [15:0] eru_in = 16'h0;
	reg [2:0] esr_pin = 3'h7;
	reg [7:0] swi_num = 8'h0;
	wire [15:0] bus_rdata, xfer_src, xfer_dst;
	wire [95:0] src_req;
	wire [5:0] hw_trap;
	wire [7:0] vec_num;
	wire trap_ret, int_done, vec_valid, vec_is_trap;
	wire xfer_valid, xfer_byte, cpu_stall;
	integer num_errors = 0;
	integer total_checks = 0;
	integer k;
	integer i;
	always #2.5 sys_clk = ~sys_clk;
	iets_top iets_top_inst (.sys_clk, .reset, .bus_addr, .bus_wdata,
		.bus_wr, .bus_rd, .bus_rdata, .src_req, .eru_in, .esr_pin,
		.hw_trap, .trap_ret, .swi_valid, .swi_num, .int_done, .jump_cache,
		.vec_valid, .vec_num, .vec_is_trap, .xfer_valid, .xfer_src,
		.xfer_dst, .xfer_byte, .cpu_stall);
	iets_partner iets_partner_inst (.sys_clk, .reset, .vec_valid,
		.vec_is_trap, .slow, .src_req, .hw_trap, .int_done, .trap_ret);
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge sys_clk);
			bus_addr <= a;
			bus_wdata <= d;
			bus_wr <= 1'b1;
			@(posedge sys_clk);
			bus_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [15:0] exp);
		begin
			@(posedge sys_clk);
			bus_addr <= a;
			bus_rd <= 1'b1;
			@(posedge sys_clk);
			bus_rd <= 1'b0;
			#1 chk(bus_rdata, exp);
		end
	endtask
	task wev(input integer lim, input x);
		begin
			k = 0;
			do begin
				@(posedge sys_clk);
				#1 k = k + 1;
			end while ((x ? xfer_valid : vec_valid) !== 1'b1 && k < lim);
		end
	endtask
	task t_pec(input [6:0] n, input [2:0] ch, input [15:0] c,
		input [15:0] e);
		reg [15:0] s;
		begin
			s = c[8] ? 16'h1 : 16'h2;
			wr({1'b0, n}, {4'h0, ch, 9'h142});
			wr({3'h4, ch, 2'h0}, c);
			wr({3'h4, ch, 2'h1}, 16'h1000);
			wr({3'h4, ch, 2'h2}, 16'h2000);
			for (i = 0; i < 2; i = i + 1) begin
				iets_partner_inst.pulse_src(96'h1 << n);
				wev(10, 1'b1);
				chk(xfer_src, 16'h1000 + (c[9] & i[0] ? s : 16'h0));
				chk(xfer_dst, 16'h2000 + (c[10] & i[0] ? s : 16'h0));
				chk({15'h0, xfer_byte}, {15'h0, c[8]});
				chk({15'h0, cpu_stall}, 16'h1);
			end
			rd({3'h4, ch, 2'h0}, e);
			$display("test transfer done");
		end
	endtask
	task t_eru(input [15:0] cfg, input [1:0] exp);
		begin
			wr(8'h68, cfg);
			for (i = 0; i < 2; i = i + 1) begin
				@(posedge sys_clk);
				eru_in[0] <= ~i[0];
				wev(20, 1'b0);
				chk({7'h0, vec_valid, vec_valid ? vec_num : 8'h0},
					{7'h0, exp[i], exp[i] ? 8'h5c : 8'h0});
				repeat (4) @(posedge sys_clk);
			end
			$display("test edge unit done");
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rd(`A_STAT, 16'h0800);
		wr(8'h05, 16'hff3f);
		rd(8'h05, 16'h0f0f);
		rd(8'h64, 16'h0);
		rd(8'ha0, 16'h0);
		$display("test registers done");
		for (i = 1; i >= 0; i = i - 1) begin
			// Realign to the edge, since the read check lands just after one.
			@(posedge sys_clk);
			jump_cache <= i[0];
			wr(8'h0a, 16'h00c2);
			wev(20, 1'b0);
			chk(k[15:0], i ? 16'h7 : 16'hb);
			chk({8'h0, vec_num}, 16'h000a);
			repeat (6) @(posedge sys_clk);
		end
		slow <= 1'b1;
		wr(8'h28, 16'h0043);
		wr(8'h29, 16'h0045);
		iets_partner_inst.pulse_src(96'h3 << 40);
		wev(30, 1'b0);
		chk({8'h0, vec_num}, 16'h0029);
		wev(60, 1'b0);
		chk({8'h0, vec_num}, 16'h0028);
		@(posedge sys_clk);
		slow <= 1'b0;
		$display("test latency and priority done");
		t_pec(7'd20, 3'd3, 16'h0602, 16'h0600);
		iets_partner_inst.pulse_src(96'h1 << 20);
		wev(30, 1'b0);
		chk({8'h0, vec_num}, 16'h0014);
		t_pec(7'd21, 3'd4, 16'h0b01, 16'h0b01);
		@(posedge sys_clk);
		swi_valid <= 1'b1;
		swi_num <= 8'h33;
		@(posedge sys_clk);
		swi_valid <= 1'b0;
		#1 chk({7'h0, vec_valid, vec_num}, 16'h0133);
		// The trap vector follows the event edge at once, so the wait
		// must already run while the pulse is driven.
		fork
			iets_partner_inst.pulse_trap(6'h01);
			wev(5, 1'b0);
		join
		chk(k[15:0], 16'h2);
		chk({7'h0, vec_is_trap, vec_num}, 16'h01f2);
		rd(`A_TRAP, 16'h0004);
		wr(8'h0a, 16'h00c2);
		wev(20, 1'b0);
		chk({15'h0, vec_valid}, 16'h0);
		wev(60, 1'b0);
		chk({8'h0, vec_num}, 16'h000a);
		wr(`A_TRAP, 16'h0004);
		rd(`A_TRAP, 16'h0000);
		$display("test trap done");
		for (i = 0; i < 2; i = i + 1) begin
			wr(`A_ESR, i ? 16'h0010 : 16'h0001);
			@(posedge sys_clk);
			esr_pin <= i ? 3'h5 : 3'h6;
			wev(5, 1'b0);
			chk(k[15:0], 16'h1);
			chk({8'h0, vec_num}, i ? 16'h00f1 : 16'h00f0);
			@(posedge sys_clk);
			esr_pin <= 3'h7;
			repeat (50) @(posedge sys_clk);
		end
		rd(`A_TRAP, 16'h0003);
		wr(`A_TRAP, 16'h00ff);
		$display("test service pins done");
		wr(`A_SRCSEL, 16'h0001);
		wr(8'h5c, 16'h0042);
		t_eru(16'h1011, 2'b01);
		t_eru(16'h1012, 2'b10);
		t_eru(16'h0013, 2'b00);
		t_eru(16'h2113, 2'b01);
		t_eru(16'h3013, 2'b01);
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors = num_errors + 1;
		give_verdict;
	end
endmodule // testbench
bind iets_top iets_assertions iets_assertions_inst (.sys_clk, .reset,
	.bus_addr, .bus_rd, .bus_rdata, .trap_ret, .swi_valid, .swi_num,
	.vec_valid, .vec_num, .vec_is_trap, .xfer_valid, .cpu_stall);
